/* File: logic_block_group.sv */
/*
  Logic block group: eight logic cells sharing four control lines, the
  carry and cascade chains through them, pin cells and an AHB-Lite slave
  holding the configuration. Assumes a single hclk; cell data, carry,
  cascade and external control lines come from logic on hclk, while the
  dedicated inputs and pins are asynchronous.
*/
// The AHB-Lite interface to the registers and the register addresses were decided locally.
// How it works
// - Eight logic cells form one block.
// - Four control lines reach every cell.
// - Lines 0,1 clock; lines 2,3 clear/preset.
// - Each line sourced dedicated, pin or local.
// - Four synchronised dedicated inputs, shared globally.
// - Cell outputs from any block drive lines.
// - Lookup table gives any four-input function.
// - Flip-flop acts as D, T, JK, SR.
// - Combinational cell bypasses its flip-flop.
// - Carry and cascade link adjacent cells, rowwide.
// - Pin cell: buffer plus one in/out register.
// - Carry-in feeds table and next stage.
// - Cascade combines by AND or OR.
// - Clear and preset low active, unused high.
// - Output selects combinational or registered value.
`timescale 1ns/100ps
`include "fabric_consts.svh"

module logic_block_group (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Dedicated global inputs
  input wire logic [`N_DED-1:0] ded_in,
  output logic [`N_DED-1:0] global_ctl,
  // Local interconnect
  input wire logic [4*`N_CELLS-1:0] cell_data,
  input wire logic [`N_CELLS-1:0] ext_ctl,
  output logic [`N_CELLS-1:0] cell_out,
  // Chains to neighbouring blocks of the row
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // Pins
  input wire logic [`N_PINS-1:0] pin_i,
  output logic [`N_PINS-1:0] pin_o,
  output logic [`N_PINS-1:0] pin_oe_n
);

  // Configuration and bus state
  logic [`LUT_BITS-1:0] lut_q [`N_CELLS];
  logic [`LUT_BITS-1:0] lut_d [`N_CELLS];
  logic [`CFG_WIDTH-1:0] cfg_q [`N_CELLS];
  logic [`CFG_WIDTH-1:0] cfg_d [`N_CELLS];
  logic [31:0] ctl_src_q;
  logic [31:0] ctl_src_d;
  logic [7:0] pin_cfg_q;
  logic [7:0] pin_cfg_d;
  logic wr_pend_q;
  logic wr_pend_d;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_addr_d;
  logic [3:0] wr_mask_q;
  logic [3:0] wr_mask_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;
  logic [31:0] wr_word;
  logic [3:0] acc_mask;
  logic acc_valid;

  // Synchronisers and fabric state
  logic [`N_DED-1:0] ded_meta_q;
  logic [`N_DED-1:0] ded_sync_q;
  logic [`N_PINS-1:0] pin_meta_q;
  logic [`N_PINS-1:0] pin_sync_q;
  logic [1:0] clk_prev_q;
  logic [1:0] clk_prev_d;
  logic [`N_PINS-1:0] pin_reg_q;
  logic [`N_PINS-1:0] pin_reg_d;

  logic [`N_CTL-1:0] ctl_line;
  logic [1:0] clk_pulse;
  logic [`N_CELLS-1:0] cell_out_w;
  logic [`N_CELLS-1:0] reg_w;
  logic [`N_CELLS:0] carry_w;
  logic [`N_CELLS:0] casc_w;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] mask);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (mask[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // Register view; unmapped offsets read zero
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if ({a[7:5], 5'h00} == `LUT_BASE)
    begin
      r[`LUT_BITS-1:0] = lut_q[a[4:2]];
    end
    else if ({a[7:5], 5'h00} == `CFG_BASE)
    begin
      r[`CFG_WIDTH-1:0] = cfg_q[a[4:2]];
    end
    else if ({a[7:2], 2'b00} == `CTL_SRC_OFS)
    begin
      r = ctl_src_q;
    end
    else if ({a[7:2], 2'b00} == `PIN_CFG_OFS)
    begin
      r[7:0] = pin_cfg_q;
    end
    else if ({a[7:2], 2'b00} == `STATUS_OFS)
    begin
      r[25:0] = {casc_w[`N_CELLS], carry_w[`N_CELLS], pin_reg_q, ctl_line, reg_w, cell_out_w};
    end
    return r;
  endfunction : reg_read

  // Bus slave: zero wait states, always OKAY
  always_comb
  begin
    hreadyout = 1'b1;
    hresp = 1'b0;
    hrdata = hrdata_q;
    acc_valid = hsel && htrans[1] && hready;
    case (hsize)
      3'b000: acc_mask = 4'b0001 << haddr[1:0];
      3'b001: acc_mask = 4'b0011 << {haddr[1], 1'b0};
      default: acc_mask = 4'b1111;
    endcase
    wr_word = merge(reg_read(wr_addr_q), hwdata, wr_mask_q);
    wr_pend_d = acc_valid && hwrite;
    wr_addr_d = acc_valid ? haddr[7:0] : wr_addr_q;
    wr_mask_d = acc_valid ? acc_mask : wr_mask_q;
    hrdata_d = hrdata_q;
    if (acc_valid && !hwrite)
    begin
      // Forward a write still in its data phase, else a back-to-back read is stale
      if (wr_pend_q && (wr_addr_q[7:2] == haddr[7:2]) && ({haddr[7:2], 2'b00} < `STATUS_OFS))
      begin
        // Trimmed to the register's width; read-only and unmapped words never forward
        hrdata_d = wr_word & (haddr[6] ? (haddr[2] ? 32'h0000_00FF : 32'hFFFF_FFFF)
                                       : (haddr[5] ? 32'h0000_07FF : 32'h0000_FFFF));
      end
      else
      begin
        hrdata_d = reg_read(haddr[7:0]);
      end
    end
  end

  always_comb
  begin
    lut_d = lut_q;
    cfg_d = cfg_q;
    ctl_src_d = ctl_src_q;
    pin_cfg_d = pin_cfg_q;
    if (wr_pend_q)
    begin
      if ({wr_addr_q[7:5], 5'h00} == `LUT_BASE)
      begin
        lut_d[wr_addr_q[4:2]] = wr_word[`LUT_BITS-1:0];
      end
      else if ({wr_addr_q[7:5], 5'h00} == `CFG_BASE)
      begin
        cfg_d[wr_addr_q[4:2]] = wr_word[`CFG_WIDTH-1:0];
      end
      else if ({wr_addr_q[7:2], 2'b00} == `CTL_SRC_OFS)
      begin
        ctl_src_d = wr_word;
      end
      else if ({wr_addr_q[7:2], 2'b00} == `PIN_CFG_OFS)
      begin
        pin_cfg_d = wr_word[7:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < `N_CELLS; c++)
      begin
        lut_q[c] <= `LUT_RST;
        cfg_q[c] <= `CFG_RST;
      end
      ctl_src_q <= `CTL_SRC_RST;
      pin_cfg_q <= `PIN_CFG_RST;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_mask_q <= 4'h0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      lut_q <= lut_d;
      cfg_q <= cfg_d;
      ctl_src_q <= ctl_src_d;
      pin_cfg_q <= pin_cfg_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
      wr_mask_q <= wr_mask_d;
      hrdata_q <= hrdata_d;
    end
  end

  // Asynchronous inputs pass two flops before any use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ded_meta_q <= '0;
      ded_sync_q <= '0;
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end
    else
    begin
      ded_meta_q <= ded_in;
      ded_sync_q <= ded_meta_q;
      pin_meta_q <= pin_i;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign global_ctl = ded_sync_q;

  // Control line sources; a cell source is taken straight from cell_out_w, with no flop
  always_comb
  begin
    for (int i = 0; i < `N_CTL; i++)
    begin
      case (fabric_pkg::ctl_src_t'(ctl_src_q[i*`CTL_FIELD + `CTL_SRC_LSB +: 2]))
        fabric_pkg::SRC_DEDICATED: ctl_line[i] = ded_sync_q[ctl_src_q[i*`CTL_FIELD + `CTL_IDX_LSB +: 2]];
        fabric_pkg::SRC_PIN: ctl_line[i] = pin_sync_q[ctl_src_q[i*`CTL_FIELD + `CTL_IDX_LSB +: 2]];
        fabric_pkg::SRC_CELL: ctl_line[i] = cell_out_w[ctl_src_q[i*`CTL_FIELD + `CTL_IDX_LSB +: 3]];
        fabric_pkg::SRC_LOCAL: ctl_line[i] = ext_ctl[ctl_src_q[i*`CTL_FIELD + `CTL_IDX_LSB +: 3]];
        default: ctl_line[i] = 1'b0;
      endcase
    end
    clk_prev_d = ctl_line[1:0];
    // Clock lines become one-cycle enables; glitchy sources give extra edges
    clk_pulse = ctl_line[1:0] & ~clk_prev_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      clk_prev_q <= 2'b00;
    end
    else
    begin
      clk_prev_q <= clk_prev_d;
    end
  end

  assign carry_w[0] = carry_in;
  assign casc_w[0] = cascade_in;

  for (genvar c = 0; c < `N_CELLS; c++)
  begin : g_cell
    logic cell_clr_n;
    logic cell_pre_n;
    logic cell_clk_en;
    // Lines 2 and 3 are clear and preset; an unused one sits high
    assign cell_clr_n = cfg_q[c][`CFG_CLR_EN] ? ctl_line[2] : 1'b1;
    assign cell_pre_n = cfg_q[c][`CFG_PRE_EN] ? ctl_line[3] : 1'b1;
    assign cell_clk_en = clk_pulse[cfg_q[c][`CFG_CLKSEL]];

    logic_cell u_cell (
      .hclk(hclk),
      .hresetn(hresetn),
      .lut_cfg(lut_q[c]),
      .cell_cfg(cfg_q[c]),
      .data_in(cell_data[4*c +: 4]),
      .carry_in(carry_w[c]),
      .cascade_in(casc_w[c]),
      .clk_en(cell_clk_en),
      .clr_n(cell_clr_n),
      .pre_n(cell_pre_n),
      .carry_out(carry_w[c+1]),
      .cascade_out(casc_w[c+1]),
      .cell_output(cell_out_w[c]),
      .reg_value(reg_w[c])
    );
  end

  assign cell_out = cell_out_w;
  assign carry_out = carry_w[`N_CELLS];
  assign cascade_out = casc_w[`N_CELLS];

  // Pin cells: one flop, either capturing the pin or holding cell p's output
  always_comb
  begin
    pin_reg_d = pin_reg_q;
    for (int p = 0; p < `N_PINS; p++)
    begin
      if (clk_pulse[0])
      begin
        pin_reg_d[p] = pin_cfg_q[`PIN_OUTREG_LSB + p] ? cell_out_w[p] : pin_sync_q[p];
      end
      pin_oe_n[p] = ~(pin_cfg_q[`PIN_DRIVE_LSB + p] & pin_cfg_q[`PIN_OUTREG_LSB + p]);
    end
    pin_o = pin_reg_q;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pin_reg_q <= '0;
    end
    else
    begin
      pin_reg_q <= pin_reg_d;
    end
  end

endmodule : logic_block_group

/* File: fabric_consts.svh */
/*
  Constants for the logic block group: sizes, register offsets, field
  positions and reset values. Definitions only; included by bare name.
*/
`ifndef FABRIC_CONSTS_SVH
`define FABRIC_CONSTS_SVH

// Sizes
`define N_CELLS 8
`define N_CTL 4
`define N_DED 4
`define N_PINS 4
`define LUT_BITS 16

// Register byte offsets, decoded on haddr[7:0]
`define LUT_BASE 8'h00
`define CFG_BASE 8'h20
`define CTL_SRC_OFS 8'h40
`define PIN_CFG_OFS 8'h44
`define STATUS_OFS 8'h48

// Cell configuration fields
`define CFG_MODE_LSB 0
`define CFG_COMB 2
`define CFG_OUTREG 3
`define CFG_CLKSEL 4
`define CFG_CASC_EN 5
`define CFG_CASC_OR 6
`define CFG_D3_CARRY 7
`define CFG_CLR_EN 8
`define CFG_PRE_EN 9
`define CFG_ARITH 10
`define CFG_WIDTH 11

// Control source fields, one byte per control line
`define CTL_FIELD 8
`define CTL_SRC_LSB 0
`define CTL_IDX_LSB 2

// Pin configuration fields
`define PIN_DRIVE_LSB 0
`define PIN_OUTREG_LSB 4

// Reset values
`define LUT_RST 16'h0000
`define CFG_RST 11'h000
`define CTL_SRC_RST 32'h0000_0000
`define PIN_CFG_RST 8'h00

`endif

/* File: fabric_pkg.sv */
/*
  Types shared by the logic block group and its logic cells.
  Assumes nothing of its surroundings.
*/
package fabric_pkg;

  typedef enum logic [1:0] {
    FF_D = 2'b00,
    FF_T = 2'b01,
    FF_JK = 2'b10,
    FF_SR = 2'b11
  } ff_mode_t;

  typedef enum logic [1:0] {
    SRC_DEDICATED = 2'b00,
    SRC_PIN = 2'b01,
    SRC_CELL = 2'b10,
    SRC_LOCAL = 2'b11
  } ctl_src_t;

endpackage : fabric_pkg

/* File: logic_cell.sv */
/*
  One logic cell: four-input lookup table, carry and cascade links and a
  programmable flip-flop. Assumes clock-line edges arrive as hclk enables
  and clear/preset as active-low levels already resolved by the block.
*/
`timescale 1ns/100ps
`include "fabric_consts.svh"

module logic_cell (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration
  input wire logic [`LUT_BITS-1:0] lut_cfg,
  input wire logic [`CFG_WIDTH-1:0] cell_cfg,
  // Data and chains
  input wire logic [3:0] data_in,
  input wire logic carry_in,
  input wire logic cascade_in,
  // Register control
  input wire logic clk_en,
  input wire logic clr_n,
  input wire logic pre_n,
  // Results
  output logic carry_out,
  output logic cascade_out,
  output logic cell_output,
  output logic reg_value
);

  fabric_pkg::ff_mode_t mode;
  logic [3:0] lut_in;
  logic lut_out;
  logic comb_out;
  logic q_q;
  logic q_d;

  always_comb
  begin
    mode = fabric_pkg::ff_mode_t'(cell_cfg[`CFG_MODE_LSB +: 2]);
    lut_in = {cell_cfg[`CFG_D3_CARRY] ? carry_in : data_in[3], data_in[2:0]};
    lut_out = lut_cfg[lut_in];
    if (cell_cfg[`CFG_CASC_EN])
    begin
      comb_out = cell_cfg[`CFG_CASC_OR] ? (lut_out | cascade_in) : (lut_out & cascade_in);
    end
    else
    begin
      comb_out = lut_out;
    end
    cascade_out = comb_out;
    // Majority of two operands and carry, else carry passes on unchanged
    if (cell_cfg[`CFG_ARITH])
    begin
      carry_out = (data_in[0] & data_in[1]) | ((data_in[0] ^ data_in[1]) & carry_in);
    end
    else
    begin
      carry_out = carry_in;
    end
  end

  // Clear beats preset; both act without waiting for a clock-line edge
  always_comb
  begin
    q_d = q_q;
    if (!clr_n)
    begin
      q_d = 1'b0;
    end
    else if (!pre_n)
    begin
      q_d = 1'b1;
    end
    else if (clk_en && !cell_cfg[`CFG_COMB])
    begin
      case (mode)
        fabric_pkg::FF_D: q_d = comb_out;
        fabric_pkg::FF_T: q_d = q_q ^ comb_out;
        fabric_pkg::FF_JK: q_d = (comb_out & ~q_q) | (~data_in[2] & q_q);
        fabric_pkg::FF_SR: q_d = comb_out | (~data_in[2] & q_q);
        default: q_d = q_q;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q_q <= 1'b0;
    end
    else
    begin
      q_q <= q_d;
    end
  end

  always_comb
  begin
    reg_value = q_q;
    if (cell_cfg[`CFG_COMB] || !cell_cfg[`CFG_OUTREG])
    begin
      cell_output = comb_out;
    end
    else
    begin
      cell_output = q_q;
    end
  end

endmodule : logic_cell

/* File: fabric_chk.sv */
/*
  Port checker for the logic block group.
  Assumes one hclk domain and the bind at the foot.
*/
`timescale 1ns/100ps
`include "fabric_consts.svh"

module fabric_chk (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Fabric
  input wire logic [3:0] ded_in,
  input wire logic [3:0] global_ctl,
  input wire logic [7:0] cell_out,
  input wire logic carry_out,
  input wire logic cascade_out,
  input wire logic [3:0] pin_oe_n
);
  logic rd_d;
  logic rd_q;
  logic [7:0] ra_d;
  logic [7:0] ra_q;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  always_comb
  begin
    rd_d = hsel && htrans[1] && hready && !hwrite;
    ra_d = rd_d ? haddr[7:0] : ra_q;
  end
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      ra_q <= 8'h00;
    end
    else
    begin
      rd_q <= rd_d;
      ra_q <= ra_d;
    end
  end
  ready_high_a: assert property (hreadyout) else $error("wait state seen");
  resp_okay_a: assert property (!hresp) else $error("error response seen");
  ded_sync_a: assert property (global_ctl == $past(ded_in, 2))
    else $error("global line lag wrong");
  rdata_hold_a: assert property (!rd_d |=> $stable(hrdata)) else $error("read data moved");
  reset_vals_a: assert property ($rose(hresetn) |-> pin_oe_n == 4'hF && global_ctl == 4'h0)
    else $error("reset values wrong");
  status_cells_a: assert property (rd_q && ra_q == `STATUS_OFS |->
    hrdata[7:0] == $past(cell_out) && hrdata[31:26] == 6'h00) else $error("status cells wrong");
  status_chain_a: assert property (rd_q && ra_q == `STATUS_OFS |->
    hrdata[25:24] == {$past(cascade_out), $past(carry_out)}) else $error("status chain wrong");
  unmapped_zero_a: assert property (rd_q && ra_q > `STATUS_OFS |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : fabric_chk

bind logic_block_group fabric_chk i_fabric_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .ded_in, .global_ctl, .cell_out,
  .carry_out, .cascade_out, .pin_oe_n);

/* File: row_neighbour.sv */
/*
  Neighbouring blocks and global inputs, registered on hclk.
  Assumes the bench sets the wanted levels between edges.
*/
`timescale 1ns/100ps

module row_neighbour (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Wanted levels
  input wire logic [3:0] ded_set,
  input wire logic [31:0] data_set,
  input wire logic carry_set,
  input wire logic casc_set,
  input wire logic [7:0] ext_set,
  // Toward the block
  output logic [3:0] ded_in,
  output logic [31:0] cell_data,
  output logic [7:0] ext_ctl,
  output logic carry_in,
  output logic cascade_in
);
  logic [45:0] out_d;
  logic [45:0] out_q;
  // Other-block cell lines and global inputs as the bench wants them
  always_comb out_d = {ded_set, data_set, ext_set, carry_set, casc_set};
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      out_q <= '0;
    else
      out_q <= out_d;
  end
  assign {ded_in, cell_data, ext_ctl, carry_in, cascade_in} = out_q;
endmodule : row_neighbour

/* File: tb_top.sv */
/*
  Bench for the logic block group over AHB-Lite.
  Assumes zero-wait slave and the neighbour model.
*/
`timescale 1ns/100ps
`include "fabric_consts.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module tb_top;
  logic hclk, hresetn, hwrite, hreadyout, hresp, carry_in, cascade_in, carry_out;
  logic cascade_out, carry_set, casc_set;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd, cell_data, data_set;
  logic [3:0] ded_in, global_ctl, ded_set, pin_o, pin_oe_n, pin_i;
  logic [7:0] ext_ctl, cell_out, ext_set;
  logic [15:0] lut;
  int fail_count, check_count;
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  logic_block_group i_logic_block_group (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ded_in(ded_in), .global_ctl(global_ctl), .cell_data(cell_data), .ext_ctl(ext_ctl),
    .cell_out(cell_out), .carry_in(carry_in), .cascade_in(cascade_in),
    .carry_out(carry_out), .cascade_out(cascade_out), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n));
  row_neighbour i_row_neighbour (.hclk(hclk), .hresetn(hresetn), .ded_set(ded_set),
    .data_set(data_set), .carry_set(carry_set), .casc_set(casc_set), .ext_set(ext_set),
    .ded_in(ded_in), .cell_data(cell_data), .ext_ctl(ext_ctl), .carry_in(carry_in),
    .cascade_in(cascade_in));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask : settle
  // Clock lines are edge detected, so each pulse needs a low spell too
  task automatic pulse(input int i);
    ded_set[i] <= 1'b1;
    settle(6);
    ded_set[i] <= 1'b0;
    settle(6);
  endtask : pulse
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    repeat (20000) @(posedge hclk);
    fail_count++;
    close_out();
  end
  initial
  begin
    {hresetn, hwrite, htrans, haddr, hwdata, ded_set, data_set, carry_set, casc_set} = '0;
    {pin_i, ext_set} = '0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    settle(2);
    `CHK("cell_out", 8'h00, cell_out)
    `CHK("carry_out", 1'b0, carry_out)
    bus(1'b0, 8'h4C, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, 8'(4 * c), 32'h0000FFFF);
      settle(1);
      `CHK("cell fill", 8'((1 << (c + 1)) - 1), cell_out)
    end
    `CHK("cascade_out", 1'b1, cascade_out)
    lut = 16'hC35A;
    bus(1'b1, `LUT_BASE, {16'h0, lut});
    bus(1'b0, `LUT_BASE, 32'h0);
    `CHK("lut readback", {16'h0, lut}, rd)
    for (int i = 0; i < 16; i++)
    begin
      data_set <= 32'(i);
      settle(2);
      `CHK("lut entry", lut[i], cell_out[0])
    end
    $display("test lookup done");
    for (int m = 0; m < 4; m++)
    begin
      bus(1'b1, `CFG_BASE, m[1] ? 32'h60 : 32'h20);
      bus(1'b1, `LUT_BASE, m[1] ? 32'h0 : 32'hFFFF);
      casc_set <= m[0];
      settle(2);
      `CHK("cascade", 1'(m), cell_out[0])
    end
    bus(1'b1, `CFG_BASE, 32'h400);
    bus(1'b1, `CFG_BASE + 8'h04, 32'h080);
    bus(1'b1, `LUT_BASE + 8'h04, 32'hFF00);
    data_set <= 32'h3;
    settle(2);
    `CHK("carry gen", 1'b1, carry_out)
    `CHK("carry lut", 1'b1, cell_out[1])
    data_set <= 32'h0;
    settle(2);
    `CHK("carry kill", 1'b0, carry_out)
    `CHK("carry lut0", 1'b0, cell_out[1])
    $display("test chains done");
    bus(1'b1, `LUT_BASE, 32'hFFFF);
    bus(1'b1, `CTL_SRC_OFS, 32'h0004_0800);
    ded_set <= 4'h2;
    bus(1'b1, `CFG_BASE, 32'h008);
    settle(6);
    `CHK("reg before", 1'b0, cell_out[0])
    pulse(0);
    `CHK("d reg", 1'b1, cell_out[0])
    bus(1'b1, `CFG_BASE, 32'h009);
    pulse(0);
    `CHK("t reg", 1'b0, cell_out[0])
    pulse(0);
    `CHK("t reg", 1'b1, cell_out[0])
    bus(1'b1, `CFG_BASE, 32'h00A);
    bus(1'b1, `LUT_BASE, 32'h0);
    data_set <= 32'h4;
    pulse(0);
    `CHK("jk reg", 1'b0, cell_out[0])
    bus(1'b1, `LUT_BASE, 32'hFFFF);
    bus(1'b1, `CFG_BASE, 32'h00B);
    pulse(0);
    `CHK("sr reg", 1'b1, cell_out[0])
    bus(1'b1, `CFG_BASE, 32'h10B);
    ded_set <= 4'h0;
    settle(6);
    `CHK("clear", 1'b0, cell_out[0])
    ded_set <= 4'h2;
    bus(1'b1, `CFG_BASE, 32'h01B);
    pulse(0);
    `CHK("line1 idle", 1'b0, cell_out[0])
    pulse(2);
    `CHK("line1 clock", 1'b1, cell_out[0])
    bus(1'b1, `LUT_BASE, 32'h0);
    bus(1'b1, `CFG_BASE, 32'h01F);
    pulse(2);
    `CHK("comb bypass", 1'b0, cell_out[0])
    bus(1'b1, `CFG_BASE, 32'h01B);
    settle(1);
    `CHK("comb held", 1'b1, cell_out[0])
    $display("test register done");
    bus(1'b1, `PIN_CFG_OFS, 32'h11);
    settle(1);
    `CHK("pin_oe_n", 4'hE, pin_oe_n)
    pin_i <= 4'h2;
    pulse(0);
    `CHK("pin_o", 1'b1, pin_o[0])
    `CHK("pin capture", 1'b1, pin_o[1])
    bus(1'b0, `STATUS_OFS, 32'h0);
    `CHK("status", 1'b1, rd[0])
    $display("test pins done");
    pulse(2);
    `CHK("sr reset", 1'b0, cell_out[0])
    bus(1'b1, `CFG_BASE, 32'h21B);
    settle(2);
    `CHK("preset", 1'b1, cell_out[0])
    bus(1'b1, `CFG_BASE + 8'h04, 32'h0);
    bus(1'b1, `LUT_BASE + 8'h04, 32'hAAAA);
    bus(1'b1, `CTL_SRC_OFS, 32'h0004_0600);
    bus(1'b1, `CFG_BASE, 32'h01B);
    data_set <= 32'h14;
    settle(3);
    `CHK("cell clock", 1'b0, cell_out[0])
    bus(1'b1, `LUT_BASE, 32'hFFFF);
    bus(1'b1, `CTL_SRC_OFS, 32'h0004_0900);
    pin_i <= 4'h6;
    settle(6);
    `CHK("pin clock", 1'b1, cell_out[0])
    bus(1'b1, `LUT_BASE, 32'h0);
    bus(1'b1, `CTL_SRC_OFS, 32'h0004_0F00);
    ext_set <= 8'h08;
    settle(3);
    `CHK("local clock", 1'b0, cell_out[0])
    $display("test sources done");
    close_out();
  end
endmodule : tb_top
